// ---- src/psw_top.sv ----
/*
  pump sleep/wake supervisor with two-point analog calibration, wishbone classic slave.
  assumes inputs synchronous to CLK_SYS and a 25 MHz clock.
*/
// How it works
// - enable 0 disables sleep and wake entirely; 1 enables pressure/frequency sleep
// - when enabled force PID frequency source, input one feedback, setpoint reference
// - running: sleep when feedback above setpoint-deviation and freq below sleep freq for delay
// - sleep delay programmable 0.0 to 3600.0 s, default 5.0 s
// - asleep: wake when feedback below setpoint times wake percent for wake delay
// - wake percent relative to setpoint as 100 percent, limited 0.0 to 100.0
// - setpoint limited to zero up to sensor range, default 3.0 bar
// - sensor range 0.0 to 600.0 bar; feedback pressure is percent times range
// - enabled: display one shows setpoint, display two shows feedback pressure
// - each analog input corrected by two measured/shown point pairs
// - analog output corrected by two target/measured point pairs
// - restore defaults reloads calibration with factory values
`timescale 1ns/1ns
`default_nettype none
`include "psw_defs.svh"
module psw_top
  import psw_pkg::*;
#(
  parameter int TICK_CYC = `PSW_TICK_CYC,
  parameter int N_AI = 3,
  parameter logic [15:0] FACT_LO = 16'h07d0,
  parameter logic [15:0] FACT_HI = 16'h1f40
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // drive status, feedback in 0.1 % of range, frequency in 0.01 Hz
  input wire logic RUN_CMD,
  input wire logic [15:0] OUT_FREQ,
  input wire logic [15:0] FEEDBACK_PCT,
  // raw analog inputs and ideal analog output, mV
  input wire logic [N_AI*16-1:0] AI_RAW,
  input wire logic [15:0] AO_IDEAL,
  // drive control
  output logic STOP_REQ,
  output logic FORCE_PID_SRC,
  output logic FORCE_AI1_FB,
  output logic FORCE_SP_REF,
  output logic [15:0] DISP_ONE,
  output logic [15:0] DISP_TWO,
  output logic [N_AI*16-1:0] AI_CORR,
  output logic [15:0] AO_CORR
);
  localparam int NCAL = 4 * N_AI + 4;

  // ==========================================
  // helpers
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // two-point line through (x1,y1),(x2,y2) evaluated at x; removes offset and gain
  function automatic logic [15:0] twopt(input logic [15:0] x, input logic [15:0] x1, input logic [15:0] y1,
                                        input logic [15:0] x2, input logic [15:0] y2);
    logic signed [47:0] num;
    logic signed [47:0] r;
    num = 48'($signed({1'b0, x}) - $signed({1'b0, x1})) * 48'($signed({1'b0, y2}) - $signed({1'b0, y1}));
    // every operand signed, so points below the first calibration point do not wrap
    r = (x2 == x1) ? $signed(48'(x)) : (48'($signed({1'b0, y1})) + num / 48'($signed({1'b0, x2}) - $signed({1'b0, x1})));
    twopt = (r < 0) ? 16'h0000 : ((r > 48'sd65535) ? 16'hffff : r[15:0]);
  endfunction : twopt

  // ==========================================
  // register file
  logic en_r, en_nxt;
  logic [15:0] sfreq_r, sfreq_nxt, sdly_r, sdly_nxt, wpct_r, wpct_nxt, wdly_r, wdly_nxt;
  logic [15:0] sp_r, sp_nxt, fs_r, fs_nxt, dev_r, dev_nxt;
  logic [15:0] cal_r [NCAL];
  logic [15:0] cal_nxt [NCAL];
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  psw_state_t st_r, st_nxt;
  logic [15:0] fb_press;
  wire logic acc = WB_CYC_I && WB_STB_I && !ack_r;
  wire logic wr = acc && WB_WE_I && WB_SEL_I[0] && WB_SEL_I[1];
  wire logic restore = wr && WB_ADR_I == `PSW_OFF_RESTORE && WB_DAT_I[0];

  always_comb begin
    en_nxt = en_r;
    sfreq_nxt = sfreq_r;
    sdly_nxt = sdly_r;
    wpct_nxt = wpct_r;
    wdly_nxt = wdly_r;
    sp_nxt = sp_r;
    fs_nxt = fs_r;
    dev_nxt = dev_r;
    for (int i = 0; i < NCAL; i++) begin
      cal_nxt[i] = cal_r[i];
    end
    ack_nxt = acc;
    rdat_nxt = rdat_r;
    if (restore) begin
      en_nxt = 1'b0;
      sfreq_nxt = `PSW_RST_SLP_FREQ;
      sdly_nxt = `PSW_RST_SLP_DLY;
      wpct_nxt = `PSW_RST_WAKE_PCT;
      wdly_nxt = `PSW_RST_WAKE_DLY;
      sp_nxt = `PSW_RST_SETPOINT;
      fs_nxt = `PSW_RST_FULL_SCALE;
      dev_nxt = `PSW_RST_DEVIATION;
      for (int i = 0; i < NCAL; i++) begin
        cal_nxt[i] = (i % 4 < 2) ? FACT_LO : FACT_HI;
      end
    end else if (wr) begin
      unique case (WB_ADR_I)
        `PSW_OFF_ENABLE: en_nxt = WB_DAT_I[0];
        `PSW_OFF_SLP_FREQ: sfreq_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_SLP_FREQ);
        `PSW_OFF_SLP_DLY: sdly_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_SLP_DLY);
        `PSW_OFF_WAKE_PCT: wpct_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_WAKE_PCT);
        `PSW_OFF_WAKE_DLY: wdly_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_SLP_DLY);
        `PSW_OFF_SETPOINT: sp_nxt = clamp(WB_DAT_I[15:0], 16'h0000, fs_r);
        `PSW_OFF_FULL_SCALE: begin
          fs_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_FULL_SCALE);
          sp_nxt = clamp(sp_r, 16'h0000, fs_nxt);
        end
        `PSW_OFF_DEVIATION: dev_nxt = clamp(WB_DAT_I[15:0], 16'h0000, `PSW_MAX_DEVIATION);
        default: begin
          for (int i = 0; i < NCAL; i++) begin
            if (WB_ADR_I == 8'(`PSW_OFF_CAL_BASE + 4 * i)) begin
              cal_nxt[i] = (i % 4 < 2) ? clamp(WB_DAT_I[15:0], `PSW_CAL_LO_MIN, `PSW_CAL_LO_MAX)
                                       : clamp(WB_DAT_I[15:0], `PSW_CAL_HI_MIN, `PSW_CAL_HI_MAX);
            end
          end
        end
      endcase
    end
    if (acc) begin
      rdat_nxt = 32'h0000_0000;
      unique case (WB_ADR_I)
        `PSW_OFF_ENABLE: rdat_nxt = {31'h0, en_r};
        `PSW_OFF_SLP_FREQ: rdat_nxt = {16'h0, sfreq_r};
        `PSW_OFF_SLP_DLY: rdat_nxt = {16'h0, sdly_r};
        `PSW_OFF_WAKE_PCT: rdat_nxt = {16'h0, wpct_r};
        `PSW_OFF_WAKE_DLY: rdat_nxt = {16'h0, wdly_r};
        `PSW_OFF_SETPOINT: rdat_nxt = {16'h0, sp_r};
        `PSW_OFF_FULL_SCALE: rdat_nxt = {16'h0, fs_r};
        `PSW_OFF_DEVIATION: rdat_nxt = {16'h0, dev_r};
        `PSW_OFF_STATUS: rdat_nxt = {fb_press, 14'h0, st_r};
        default: begin
          for (int i = 0; i < NCAL; i++) begin
            if (WB_ADR_I == 8'(`PSW_OFF_CAL_BASE + 4 * i)) begin
              rdat_nxt = {16'h0, cal_r[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      en_r <= 1'b0;
      sfreq_r <= `PSW_RST_SLP_FREQ;
      sdly_r <= `PSW_RST_SLP_DLY;
      wpct_r <= `PSW_RST_WAKE_PCT;
      wdly_r <= `PSW_RST_WAKE_DLY;
      sp_r <= `PSW_RST_SETPOINT;
      fs_r <= `PSW_RST_FULL_SCALE;
      dev_r <= `PSW_RST_DEVIATION;
      for (int i = 0; i < NCAL; i++) begin
        cal_r[i] <= (i % 4 < 2) ? FACT_LO : FACT_HI;
      end
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      en_r <= en_nxt;
      sfreq_r <= sfreq_nxt;
      sdly_r <= sdly_nxt;
      wpct_r <= wpct_nxt;
      wdly_r <= wdly_nxt;
      sp_r <= sp_nxt;
      fs_r <= fs_nxt;
      dev_r <= dev_nxt;
      cal_r <= cal_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;

  // ==========================================
  // sleep/wake supervisor
  logic [31:0] prod_fb;
  logic [31:0] prod_wk;
  logic [15:0] wake_lvl;
  logic sleep_cond, wake_cond;
  logic [23:0] pre_r, pre_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic tick;

  // feedback 0.1 % times range 0.1 bar, result in 0.1 bar
  assign prod_fb = FEEDBACK_PCT * fs_r;
  assign fb_press = prod_fb[15:0] == 16'h0 && prod_fb < 32'd1000 ? 16'h0 : 16'(prod_fb / 32'd1000);
  assign prod_wk = sp_r * wpct_r;
  assign wake_lvl = 16'(prod_wk / 32'd1000);
  assign sleep_cond = RUN_CMD && {1'b0, fb_press} + {1'b0, dev_r} > {1'b0, sp_r}
                      && OUT_FREQ < sfreq_r;
  assign wake_cond = fb_press < wake_lvl;
  assign tick = pre_r == 24'(TICK_CYC - 1);

  always_comb begin
    st_nxt = st_r;
    pre_nxt = tick ? 24'h0 : pre_r + 24'h1;
    tick_nxt = tick_r;
    unique case (st_r)
      PSW_IDLE: begin
        tick_nxt = 16'h0;
        pre_nxt = 24'h0;
        if (en_r) st_nxt = PSW_REGULATE;
      end
      PSW_REGULATE: begin
        if (!sleep_cond) begin
          tick_nxt = 16'h0;
          pre_nxt = 24'h0;
        end else if (tick_r >= sdly_r) begin
          st_nxt = PSW_SLEEP;
          tick_nxt = 16'h0;
          pre_nxt = 24'h0;
        end else if (tick) begin
          tick_nxt = tick_r + 16'h1;
        end
      end
      PSW_SLEEP: begin
        if (!wake_cond) begin
          tick_nxt = 16'h0;
          pre_nxt = 24'h0;
        end else if (tick_r >= wdly_r) begin
          st_nxt = PSW_REGULATE;
          tick_nxt = 16'h0;
          pre_nxt = 24'h0;
        end else if (tick) begin
          tick_nxt = tick_r + 16'h1;
        end
      end
      default: st_nxt = PSW_IDLE;
    endcase
    if (!en_r) st_nxt = PSW_IDLE;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_r <= PSW_IDLE;
      pre_r <= 24'h0;
      tick_r <= 16'h0;
    end else begin
      st_r <= st_nxt;
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ==========================================
  // outputs and calibration
  logic [15:0] d1_r, d1_nxt, d2_r, d2_nxt, ao_r, ao_nxt;
  logic [N_AI*16-1:0] ai_r, ai_nxt;
  always_comb begin
    d1_nxt = en_r ? sp_r : 16'h0;
    d2_nxt = en_r ? fb_press : 16'h0;
    // target maps to measured; invert so the pin lands on target
    ao_nxt = twopt(AO_IDEAL, cal_r[NCAL-3], cal_r[NCAL-4], cal_r[NCAL-1], cal_r[NCAL-2]);
    ai_nxt = '0;
    for (int k = 0; k < N_AI; k++) begin
      ai_nxt[k*16 +: 16] = twopt(AI_RAW[k*16 +: 16], cal_r[4*k], cal_r[4*k+1], cal_r[4*k+2], cal_r[4*k+3]);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      d1_r <= 16'h0;
      d2_r <= 16'h0;
      ao_r <= 16'h0;
      ai_r <= '0;
    end else begin
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
      ao_r <= ao_nxt;
      ai_r <= ai_nxt;
    end
  end

  assign STOP_REQ = st_r == PSW_SLEEP;
  assign FORCE_PID_SRC = en_r;
  assign FORCE_AI1_FB = en_r;
  assign FORCE_SP_REF = en_r;
  assign DISP_ONE = d1_r;
  assign DISP_TWO = d2_r;
  assign AO_CORR = ao_r;
  assign AI_CORR = ai_r;

  // ==========================================
  // checks
  AST_DISABLE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !en_r |=> st_r == PSW_IDLE && !STOP_REQ) else $error("sleep active while disabled");
  AST_FORCE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    FORCE_PID_SRC == en_r && FORCE_AI1_FB == en_r && FORCE_SP_REF == en_r) else $error("forcing not tied to enable");
  AST_SLEEP_NEEDS_COND: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(STOP_REQ) |-> $past(sleep_cond)) else $error("sleep without condition");
  AST_SLEEP_DELAY: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(STOP_REQ) |-> $past(tick_r) >= $past(sdly_r)) else $error("sleep before delay");
  AST_WAKE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $fell(STOP_REQ) && en_r |-> $past(wake_cond) && $past(tick_r) >= $past(wdly_r)) else $error("bad wake");
  AST_PCT_LIM: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    wpct_r <= `PSW_MAX_WAKE_PCT) else $error("wake percent above limit");
  AST_SP_LIM: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sp_r <= fs_r) else $error("setpoint above range");
  AST_DISP: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    en_r && $stable(en_r) && $stable(sp_r) |=> DISP_ONE == $past(sp_r)) else $error("display one wrong");
  AST_RESTART: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st_r == PSW_REGULATE && !sleep_cond |=> tick_r == 16'h0) else $error("timer not restarted");
  AST_RESTORE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    restore |=> cal_r[0] == FACT_LO && cal_r[2] == FACT_HI) else $error("restore missed factory value");
endmodule : psw_top
`default_nettype wire

// ---- src/psw_defs.svh ----
/*
  register offsets, reset values and timing constants of the pump sleep/wake supervisor.
  assumes inclusion by bare name from the design files.
*/
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
// ==========================================
// register word offsets (byte addresses)
`define PSW_OFF_ENABLE 8'h00
`define PSW_OFF_SLP_FREQ 8'h04
`define PSW_OFF_SLP_DLY 8'h08
`define PSW_OFF_WAKE_PCT 8'h0c
`define PSW_OFF_WAKE_DLY 8'h10
`define PSW_OFF_SETPOINT 8'h14
`define PSW_OFF_FULL_SCALE 8'h18
`define PSW_OFF_DEVIATION 8'h1c
`define PSW_OFF_STATUS 8'h20
`define PSW_OFF_RESTORE 8'h24
`define PSW_OFF_CAL_BASE 8'h40
// ==========================================
// reset values (0.01 Hz, 0.1 s, 0.1 %, 0.1 bar, 1 mV)
`define PSW_RST_ENABLE 16'h0000
`define PSW_RST_SLP_FREQ 16'h07d0
`define PSW_RST_SLP_DLY 16'h0032
`define PSW_RST_WAKE_PCT 16'h0258
`define PSW_RST_WAKE_DLY 16'h001e
`define PSW_RST_SETPOINT 16'h001e
`define PSW_RST_FULL_SCALE 16'h0064
`define PSW_RST_DEVIATION 16'h0001
// ==========================================
// limits
`define PSW_MAX_SLP_DLY 16'h8ca0
`define PSW_MAX_WAKE_PCT 16'h03e8
`define PSW_MAX_FULL_SCALE 16'h1770
`define PSW_MAX_DEVIATION 16'h04b0
`define PSW_MAX_SLP_FREQ 16'h1388
`define PSW_CAL_LO_MIN 16'h01f4
`define PSW_CAL_LO_MAX 16'h0fa0
`define PSW_CAL_HI_MIN 16'h1770
`define PSW_CAL_HI_MAX 16'h270f
// ==========================================
// timing: one delay tick is 0.1 s
`define PSW_TICK_NS 100000000
`define PSW_CLK_NS 40
`define PSW_TICK_CYC (`PSW_TICK_NS / `PSW_CLK_NS)
`endif

// ---- src/psw_pkg.sv ----
/*
  types of the pump sleep/wake supervisor.
  assumes nothing of its surroundings.
*/
package psw_pkg;
  typedef enum logic [1:0] {
    PSW_IDLE = 2'b00,
    PSW_REGULATE = 2'b01,
    PSW_SLEEP = 2'b10
  } psw_state_t;
endpackage : psw_pkg

// ---- tb/psw_top_tb.sv ----
/*
  self-checking bench of the pump sleep/wake supervisor: registers, sleep/wake, calibration.
  assumes psw_top with a short delay tick and identity factory calibration points.
*/
`timescale 1ns/1ns
`default_nettype none
`include "psw_defs.svh"
module psw_top_tb;
  // ==========================================
  // stimulus and observation
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic run = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [15:0] freq = 16'h03e8;
  logic [15:0] fb = 16'h0000;
  logic [15:0] ao = 16'h1388;
  logic [47:0] ai = 48'h1388_1388_1388;
  logic ack, stop, fpid, fai, fsp;
  logic [15:0] d1, d2, aoc;
  logic [47:0] aic;
  int n_errors = 0;
  int checks_done = 0;
  logic [7:0] offs [8] = '{`PSW_OFF_ENABLE, `PSW_OFF_SLP_FREQ, `PSW_OFF_SLP_DLY, `PSW_OFF_WAKE_PCT,
    `PSW_OFF_WAKE_DLY, `PSW_OFF_SETPOINT, `PSW_OFF_FULL_SCALE, `PSW_OFF_DEVIATION};
  logic [15:0] rstv [8] = '{`PSW_RST_ENABLE, `PSW_RST_SLP_FREQ, `PSW_RST_SLP_DLY, `PSW_RST_WAKE_PCT,
    `PSW_RST_WAKE_DLY, `PSW_RST_SETPOINT, `PSW_RST_FULL_SCALE, `PSW_RST_DEVIATION};
  always #20 clk = ~clk;
  psw_top #(.TICK_CYC(TK)) i_dut (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(q), .WB_ACK_O(ack),
    .RUN_CMD(run), .OUT_FREQ(freq), .FEEDBACK_PCT(fb), .AI_RAW(ai), .AO_IDEAL(ao), .STOP_REQ(stop),
    .FORCE_PID_SRC(fpid), .FORCE_AI1_FB(fai), .FORCE_SP_REF(fsp), .DISP_ONE(d1), .DISP_TWO(d2),
    .AI_CORR(aic), .AO_CORR(aoc));
  // ==========================================
  // shared tasks
  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // read data is taken at the very edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = q;
    if (n >= 16) begin
      n_errors++;
      results();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e, "register read");
  endtask : rdc
  task automatic wait_stop(input logic v);
    int n;
    n = 0;
    while (stop !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(stop, v, "stop request");
    if (stop !== v) begin
      results();
    end
  endtask : wait_stop
  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdc(offs[i], {16'h0000, rstv[i]});
    end
    wb(1'b1, 8'h30, 32'h0000_ffff);
    rdc(8'h30, 32'h0);
    rdc(`PSW_OFF_CAL_BASE, 32'h0000_07d0);
    chk({stop, fpid, fai, fsp, d1}, 20'h0, "outputs after reset");
  endtask : t_reset
  task automatic t_clamp();
    wb(1'b1, `PSW_OFF_WAKE_PCT, 32'h0000_07d0);
    rdc(`PSW_OFF_WAKE_PCT, {16'h0000, `PSW_MAX_WAKE_PCT});
    wb(1'b1, `PSW_OFF_SLP_DLY, 32'h0000_9000);
    rdc(`PSW_OFF_SLP_DLY, {16'h0000, `PSW_MAX_SLP_DLY});
    wb(1'b1, `PSW_OFF_FULL_SCALE, 32'h0000_1b58);
    rdc(`PSW_OFF_FULL_SCALE, {16'h0000, `PSW_MAX_FULL_SCALE});
    wb(1'b1, `PSW_OFF_SETPOINT, 32'h0000_0064);
    wb(1'b1, `PSW_OFF_FULL_SCALE, 32'h0000_0032);
    rdc(`PSW_OFF_SETPOINT, 32'h0000_0032);
    wb(1'b1, `PSW_OFF_RESTORE, 32'h1);
    rdc(`PSW_OFF_SETPOINT, {16'h0000, `PSW_RST_SETPOINT});
  endtask : t_clamp
  task automatic t_sleep();
    wb(1'b1, `PSW_OFF_SLP_DLY, 32'h0000_0003);
    wb(1'b1, `PSW_OFF_WAKE_DLY, 32'h0000_0001);
    fb <= 16'h03e8;
    run <= 1'b1;
    wb(1'b1, `PSW_OFF_ENABLE, 32'h1);
    repeat (9) @(posedge clk);
    chk({fpid, fai, fsp, stop}, 4'he, "forced sources");
    chk({d1, d2}, 32'h001e_0064, "displays");
    freq <= 16'h0bb8;
    repeat (2) @(posedge clk);
    freq <= 16'h03e8;
    repeat (7) @(posedge clk);
    chk(stop, 1'b0, "timer restart");
    wait_stop(1'b1);
    rdc(`PSW_OFF_STATUS, {16'h0064, 16'(psw_pkg::PSW_SLEEP)});
    fb <= 16'h00b4;
    repeat (12) @(posedge clk);
    chk(stop, 1'b1, "no wake at threshold");
    fb <= 16'h00aa;
    wait_stop(1'b0);
    wb(1'b1, `PSW_OFF_ENABLE, 32'h0);
    fb <= 16'h03e8;
    repeat (30) @(posedge clk);
    chk({fpid, fai, fsp, stop, d1}, 20'h0, "disabled");
    run <= 1'b0;
  endtask : t_sleep
  task automatic t_cal();
    chk({aic, aoc}, 64'h1388_1388_1388_1388, "identity correction");
    wb(1'b1, `PSW_OFF_CAL_BASE + 8'h0c, 32'h0000_2328);
    ai <= 48'h1388_1388_1f40;
    repeat (4) @(posedge clk);
    chk(aic, 48'h1388_1388_2328, "input gain point");
    // output measured point 1 moved to 3.000 V: a 2.000 V target needs 0.800 V commanded
    wb(1'b1, `PSW_OFF_CAL_BASE + 8'h34, 32'h0000_0bb8);
    ao <= 16'h07d0;
    repeat (4) @(posedge clk);
    chk(aoc, 16'h0320, "output gain point");
    wb(1'b1, `PSW_OFF_CAL_BASE, 32'h0000_0064);
    rdc(`PSW_OFF_CAL_BASE, {16'h0000, `PSW_CAL_LO_MIN});
    wb(1'b1, `PSW_OFF_RESTORE, 32'h1);
    rdc(`PSW_OFF_CAL_BASE + 8'h0c, 32'h0000_1f40);
    rdc(`PSW_OFF_CAL_BASE, 32'h0000_07d0);
    repeat (4) @(posedge clk);
    chk(aic, 48'h1388_1388_1f40, "factory correction");
  endtask : t_cal
  // ==========================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_clamp();
    t_sleep();
    t_cal();
    results();
  end
endmodule : psw_top_tb
`default_nettype wire
